// File: arc_trip_defines.svh
// offsets, field positions, reset values and timing for the arc trip block
// assumes a 25 MHz clock and 32-bit AXI4-Lite word addressing
`ifndef ARC_TRIP_DEFINES_SVH
`define ARC_TRIP_DEFINES_SVH
// ==========================================================
// timing
`define CLK_KHZ          25000
`define PROG_CYCLE_US    1000
`define BLOCK_LEAD_MS    5
`define REC_DEPTH        12
// ==========================================================
// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STAGE_EN     8'h04
`define OFS_ON_SEL       8'h08
`define OFS_OFF_SEL      8'h0C
`define OFS_LIGHT_EN     8'h10
`define OFS_CMD          8'h14
`define OFS_COND         8'h18
`define OFS_SENSOR       8'h1C
`define OFS_COUNT        8'h20
`define OFS_REC_SEL      8'h24
`define OFS_REC_W0       8'h28
`define OFS_REC_W1       8'h2C
`define OFS_REC_W2       8'h30
`define OFS_REC_W3       8'h34
// ==========================================================
// control fields and reset values
`define CTRL_FORCE_EN    0
`define CTRL_LN_ALLOW    1
`define CTRL_FORCE_LSB   2
`define CTRL_LN_LSB      4
`define CMD_CLR_ARC      0
`define CMD_CLR_COM      1
`define RST_SEL          28'hFFFFFFF
`define NUM_EVT          28
`define NUM_ARC_EVT      26
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// File: arc_trip_event_logic.sv
// arc fault stage trip/block decision, events, records, common signals
// assumes time, currents and sensor flags come in synchronous to aclk
// Contract
// - blocking input sampled once at start of each program cycle
// - zone pick-up rising with blocking inactive asserts the zone trip
// - pick-up rising with blocking active gives blocked, nothing further
// - every status change makes an event; ON/OFF storage selectable
// - each event carries the time stamp of its status change
// - cumulative arc event counter, cleared by a command
// - arc events: zone trip/block, currents, light, pressure, faults
// - twelve most recent trip records kept, oldest overwritten
// - record: time, event, three phase and residual current, sensors, group
// - condition shows trip or blocked for each of four zones
// - sensor status flags for currents, channels, input and faults
// - logical node behaviour reported, visible only when allowed
// - common start/trip follow any activated stage's start/trip
// - extra assigned signals ORed into common start
// - extra assigned signals ORed into common trip
// - force Start/Trip overrides, only with forcing enabled; force Normal overrides nothing
// - aggregator condition reported as Normal, Start or Trip
// - aggregator has no blocking input
// - common start/trip ON/OFF events, selectable, resettable counter
// - aggregator settings static, untouched by setting group change
// - enabled light channel acts as trip condition of the zone
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`include "arc_trip_defines.svh"
module arc_trip_event_logic #(
	parameter int PROG_CYCLES = `PROG_CYCLE_US * `CLK_KHZ / 1000
) (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// axi4-lite slave
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// arc stage inputs
	input  wire logic                     stage_block,
	input  wire logic [3:0]               zone_pickup,
	input  wire arc_trip_pkg::sensor_type sensors,
	input  wire arc_trip_pkg::current_type currents,
	input  wire logic [2:0]               active_group,
	input  wire logic [47:0]              rtc_ms,
	// other stages and extra assigned signals
	input  wire logic [7:0]               stage_start,
	input  wire logic [7:0]               stage_trip,
	input  wire logic                     extra_start,
	input  wire logic                     extra_trip,
	// outputs
	output logic [3:0]                    zone_trip,
	output logic [3:0]                    zone_blocked,
	output logic                          common_start,
	output logic                          common_trip,
	output arc_trip_pkg::cond_type        common_cond,
	output logic                          ln_visible,
	output arc_trip_pkg::ln_type          ln_behaviour,
	output arc_trip_pkg::event_type       event_out
);

// ==========================================================
// state
typedef struct packed {
	logic [31:0]                    div;
	logic                           tick;
	logic                           blk_s;
	logic [3:0]                     pick_prev;
	logic [3:0]                     trip;
	logic [3:0]                     blkd;
	logic [`NUM_EVT-1:0]            mon_prev;
	logic [`NUM_EVT-1:0]            pend_on;
	logic [`NUM_EVT-1:0]            pend_off;
	logic [47:0]                    stamp;
	logic [15:0]                    arc_cnt;
	logic [15:0]                    com_cnt;
	arc_trip_pkg::record_type [`REC_DEPTH-1:0] rec;
	logic [3:0]                     head;
	logic [3:0]                     rec_sel;
	logic [6:0]                     ctrl;
	logic [7:0]                     stage_en;
	logic [`NUM_EVT-1:0]            on_sel;
	logic [`NUM_EVT-1:0]            off_sel;
	logic [15:0]                    light_en;
	logic                           aw_full;
	logic [7:0]                     awaddr;
	logic                           w_full;
	logic [31:0]                    wdata;
	logic [3:0]                     wstrb;
	logic                           bvalid;
	logic [1:0]                     bresp;
	logic                           rvalid;
	logic [31:0]                    rdata;
	logic [1:0]                     rresp;
	arc_trip_pkg::event_type        evt;
} state_type;

state_type cur_ff;
state_type nxt_ff;

// ==========================================================
// helpers
function automatic logic [4:0] lowest(input logic [`NUM_EVT-1:0] v);
	logic [4:0] idx;
	idx = 5'h00;
	for (int i = `NUM_EVT - 1; i >= 0; i--) begin
		if (v[i]) begin
			idx = 5'(i);
		end
	end
	return idx;
endfunction

function automatic logic [31:0] merge(input logic [31:0] old,
	input logic [31:0] data, input logic [3:0] strb);
	logic [31:0] res;
	res = old;
	for (int b = 0; b < 4; b++) begin
		if (strb[b]) begin
			res[b*8 +: 8] = data[b*8 +: 8];
		end
	end
	return res;
endfunction

// ==========================================================
// combinational views
logic [3:0]                     zone_hit;
logic [`NUM_EVT-1:0]            mon_now;
logic                           force_on;
arc_trip_pkg::force_type        force_sel;
arc_trip_pkg::ln_type           ln_mode;
logic                           eff_block;
logic                           start_or;
logic                           trip_or;
arc_trip_pkg::record_type       rec_view;

always_comb begin
	force_on  = cur_ff.ctrl[`CTRL_FORCE_EN];
	force_sel = arc_trip_pkg::force_type'(cur_ff.ctrl[`CTRL_FORCE_LSB +: 2]);
	ln_mode   = arc_trip_pkg::ln_type'(cur_ff.ctrl[`CTRL_LN_LSB +: 3]);
	for (int z = 0; z < 4; z++) begin
		zone_hit[z] = zone_pickup[z] |
			(|(sensors.light & cur_ff.light_en[z*4 +: 4]));
	end
	// node in blocked behaviour acts as a held block input
	eff_block = cur_ff.blk_s || ln_mode == arc_trip_pkg::LN_BLOCKED ||
		ln_mode == arc_trip_pkg::LN_TEST_BLOCKED;
	// no block term reaches the aggregator at all
	start_or = |(stage_start & cur_ff.stage_en) | extra_start;
	trip_or  = |(stage_trip & cur_ff.stage_en) | (|cur_ff.trip) |
		extra_trip;
	if (force_on && force_sel == arc_trip_pkg::FORCE_TRIP) begin
		trip_or  = 1'b1;
		start_or = 1'b1;
	end else if (force_on && force_sel == arc_trip_pkg::FORCE_START) begin
		start_or = 1'b1;
	end
	mon_now = {trip_or, start_or, sensors.io_fault, sensors.sensor_fault,
		sensors.di, sensors.pressure, sensors.light, sensors.res_start,
		sensors.res_blocked, sensors.ph_start, sensors.ph_blocked,
		cur_ff.blkd, cur_ff.trip};
	rec_view = (cur_ff.rec_sel < 4'(`REC_DEPTH)) ?
		cur_ff.rec[cur_ff.rec_sel] : '0;
end

// ==========================================================
// next state
logic [4:0]  pick;
logic        pick_off;
logic        clr_arc;
logic        clr_com;
logic [7:0]  rd_addr;
logic [31:0] rd_val;
logic        rd_ok;

always_comb begin
	nxt_ff   = cur_ff;
	pick     = 5'h00;
	pick_off = 1'b0;
	clr_arc  = 1'b0;
	clr_com  = 1'b0;
	rd_addr  = s_axi_araddr;
	rd_val   = 32'h0000_0000;
	rd_ok    = 1'b1;
	// program cycle divider
	nxt_ff.tick = 1'b0;
	if (cur_ff.div >= 32'(PROG_CYCLES - 1)) begin
		nxt_ff.div  = 32'h0000_0000;
		nxt_ff.tick = 1'b1;
	end else begin
		nxt_ff.div = cur_ff.div + 32'h0000_0001;
	end
	if (cur_ff.tick) begin
		// source must lead the operate delay by BLOCK_LEAD_MS
		nxt_ff.blk_s = stage_block;
		nxt_ff.pick_prev = zone_hit;
		for (int z = 0; z < 4; z++) begin
			if (!zone_hit[z]) begin
				nxt_ff.trip[z] = 1'b0;
				nxt_ff.blkd[z] = 1'b0;
			end else if (!cur_ff.pick_prev[z] &&
				ln_mode != arc_trip_pkg::LN_OFF) begin
				nxt_ff.trip[z] = !eff_block;
				nxt_ff.blkd[z] = eff_block;
			end
		end
		// edges only at the cycle boundary, so one of each per cycle
		nxt_ff.pend_on  = cur_ff.pend_on | (mon_now & ~cur_ff.mon_prev);
		nxt_ff.pend_off = cur_ff.pend_off | (~mon_now & cur_ff.mon_prev);
		nxt_ff.mon_prev = mon_now;
		nxt_ff.stamp    = rtc_ms;
		for (int z = 0; z < 4; z++) begin
			if (cur_ff.trip[z] && !cur_ff.mon_prev[z]) begin
				nxt_ff.rec[nxt_ff.head] = '{stamp: rtc_ms,
					code: 6'(z), group: active_group,
					sensors: sensors.light | sensors.pressure,
					cur: currents};
				nxt_ff.head = (nxt_ff.head == 4'(`REC_DEPTH - 1)) ?
					4'h0 : nxt_ff.head + 4'h1;
			end
		end
	end
	// drain one pending event per clock, OFF after ON for the same index
	nxt_ff.evt.valid = 1'b0;
	if (|cur_ff.pend_on) begin
		pick = lowest(cur_ff.pend_on);
		// a fresh edge at the tick outranks the drain
		nxt_ff.pend_on[pick] = cur_ff.tick && mon_now[pick] &&
			!cur_ff.mon_prev[pick];
	end else if (|cur_ff.pend_off) begin
		pick = lowest(cur_ff.pend_off);
		pick_off = 1'b1;
		nxt_ff.pend_off[pick] = cur_ff.tick && !mon_now[pick] &&
			cur_ff.mon_prev[pick];
	end
	if (|(cur_ff.pend_on | cur_ff.pend_off)) begin
		nxt_ff.evt.valid = pick_off ? cur_ff.off_sel[pick] :
			cur_ff.on_sel[pick];
		nxt_ff.evt.code  = {pick_off, pick};
		nxt_ff.evt.stamp = cur_ff.stamp;
	end
	// axi write channel capture, either order
	if (s_axi_awvalid && s_axi_awready) begin
		nxt_ff.aw_full = 1'b1;
		nxt_ff.awaddr  = s_axi_awaddr;
	end
	if (s_axi_wvalid && s_axi_wready) begin
		nxt_ff.w_full = 1'b1;
		nxt_ff.wdata  = s_axi_wdata;
		nxt_ff.wstrb  = s_axi_wstrb;
	end
	if (cur_ff.bvalid && s_axi_bready) begin
		nxt_ff.bvalid = 1'b0;
	end
	if (cur_ff.aw_full && cur_ff.w_full && !cur_ff.bvalid) begin
		nxt_ff.aw_full = 1'b0;
		nxt_ff.w_full  = 1'b0;
		nxt_ff.bvalid  = 1'b1;
		nxt_ff.bresp   = `RESP_OKAY;
		unique case (cur_ff.awaddr)
			`OFS_CTRL: begin
				nxt_ff.ctrl = 7'(merge(32'(cur_ff.ctrl), cur_ff.wdata,
					cur_ff.wstrb));
			end
			`OFS_STAGE_EN: begin
				nxt_ff.stage_en = 8'(merge(32'(cur_ff.stage_en),
					cur_ff.wdata, cur_ff.wstrb));
			end
			`OFS_ON_SEL: begin
				nxt_ff.on_sel = 28'(merge(32'(cur_ff.on_sel),
					cur_ff.wdata, cur_ff.wstrb));
			end
			`OFS_OFF_SEL: begin
				nxt_ff.off_sel = 28'(merge(32'(cur_ff.off_sel),
					cur_ff.wdata, cur_ff.wstrb));
			end
			`OFS_LIGHT_EN: begin
				nxt_ff.light_en = 16'(merge(32'(cur_ff.light_en),
					cur_ff.wdata, cur_ff.wstrb));
			end
			`OFS_CMD: begin
				clr_arc = cur_ff.wstrb[0] && cur_ff.wdata[`CMD_CLR_ARC];
				clr_com = cur_ff.wstrb[0] && cur_ff.wdata[`CMD_CLR_COM];
			end
			`OFS_REC_SEL: begin
				if (cur_ff.wstrb[0]) begin
					nxt_ff.rec_sel = cur_ff.wdata[3:0];
				end
			end
			`OFS_COND, `OFS_SENSOR, `OFS_COUNT, `OFS_REC_W0, `OFS_REC_W1,
			`OFS_REC_W2, `OFS_REC_W3: begin
			end
			default: begin
				nxt_ff.bresp = `RESP_SLVERR;
			end
		endcase
	end
	// counters: clear first, then the current event, so none is lost
	if (clr_arc) begin
		nxt_ff.arc_cnt = 16'h0000;
	end
	if (clr_com) begin
		nxt_ff.com_cnt = 16'h0000;
	end
	if (|(cur_ff.pend_on | cur_ff.pend_off)) begin
		if (pick < 5'(`NUM_ARC_EVT)) begin
			nxt_ff.arc_cnt = nxt_ff.arc_cnt + 16'h0001;
		end else if (!pick_off) begin
			nxt_ff.com_cnt = nxt_ff.com_cnt + 16'h0001;
		end
	end
	// axi read channel
	unique case (rd_addr)
		`OFS_CTRL:     rd_val = 32'(cur_ff.ctrl);
		`OFS_STAGE_EN: rd_val = 32'(cur_ff.stage_en);
		`OFS_ON_SEL:   rd_val = 32'(cur_ff.on_sel);
		`OFS_OFF_SEL:  rd_val = 32'(cur_ff.off_sel);
		`OFS_LIGHT_EN: rd_val = 32'(cur_ff.light_en);
		`OFS_CMD:      rd_val = 32'h0000_0000;
		`OFS_COND:     rd_val = {22'h000000, common_cond, cur_ff.blkd,
			cur_ff.trip};
		`OFS_SENSOR:   rd_val = 32'(sensors);
		`OFS_COUNT:    rd_val = {cur_ff.com_cnt, cur_ff.arc_cnt};
		`OFS_REC_SEL:  rd_val = {24'h000000, cur_ff.head, cur_ff.rec_sel};
		`OFS_REC_W0:   rd_val = rec_view.stamp[31:0];
		`OFS_REC_W1:   rd_val = {3'h0, rec_view.stamp[47:32],
			rec_view.code, rec_view.group, rec_view.sensors};
		`OFS_REC_W2:   rd_val = {rec_view.cur.ia, rec_view.cur.ib};
		`OFS_REC_W3:   rd_val = {rec_view.cur.ic, rec_view.cur.i0};
		default:       rd_ok = 1'b0;
	endcase
	if (cur_ff.rvalid && s_axi_rready) begin
		nxt_ff.rvalid = 1'b0;
	end
	if (s_axi_arvalid && s_axi_arready) begin
		nxt_ff.rvalid = 1'b1;
		nxt_ff.rdata  = rd_ok ? rd_val : 32'h0000_0000;
		nxt_ff.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
	end
end

// ==========================================================
// registers
always_ff @(posedge aclk) begin
	if (!aresetn) begin
		cur_ff         <= '0;
		cur_ff.on_sel  <= `RST_SEL;
		cur_ff.off_sel <= `RST_SEL;
	end else begin
		cur_ff <= nxt_ff;
	end
end

// ==========================================================
// outputs
always_comb begin
	s_axi_awready = !cur_ff.aw_full;
	s_axi_wready  = !cur_ff.w_full;
	s_axi_bvalid  = cur_ff.bvalid;
	s_axi_bresp   = cur_ff.bresp;
	s_axi_arready = !cur_ff.rvalid;
	s_axi_rvalid  = cur_ff.rvalid;
	s_axi_rdata   = cur_ff.rdata;
	s_axi_rresp   = cur_ff.rresp;
	zone_trip     = cur_ff.trip;
	zone_blocked  = cur_ff.blkd;
	common_start  = cur_ff.mon_prev[`NUM_EVT-2];
	common_trip   = cur_ff.mon_prev[`NUM_EVT-1];
	if (common_trip) begin
		common_cond = arc_trip_pkg::COND_TRIP;
	end else if (common_start) begin
		common_cond = arc_trip_pkg::COND_START;
	end else begin
		common_cond = arc_trip_pkg::COND_NORMAL;
	end
	ln_visible   = cur_ff.ctrl[`CTRL_LN_ALLOW];
	ln_behaviour = ln_visible ? ln_mode : arc_trip_pkg::LN_ON;
	event_out    = cur_ff.evt;
end

endmodule

// File: arc_trip_event_logic_asserts.sv
// concurrent checks on the arc trip block's ports
// assumes one clock domain and the bind at the foot of this file
module arc_trip_event_logic_asserts #(
	parameter int PROG_CYCLES = 16
) (
	// clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// stage side
	input wire logic                    stage_block,
	input wire logic [3:0]              zone_pickup,
	input wire logic [47:0]             rtc_ms,
	input wire logic                    extra_start,
	input wire logic                    extra_trip,
	// outputs
	input wire logic [3:0]              zone_trip,
	input wire logic [3:0]              zone_blocked,
	input wire logic                    common_start,
	input wire logic                    common_trip,
	input wire arc_trip_pkg::cond_type  common_cond,
	input wire logic                    ln_visible,
	input wire arc_trip_pkg::ln_type    ln_behaviour,
	input wire arc_trip_pkg::event_type event_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// one full program cycle plus the register stages
	localparam int LIM = PROG_CYCLES + 3;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// stage decisions
	property p_zone_mutex;
		(zone_trip & zone_blocked) == 4'h0;
	endproperty
	a_zone_mutex: assert property (p_zone_mutex)
		else $error("zone both tripped and blocked");
	property p_trip_cause;
		(zone_trip & ~$past(zone_trip)) != 4'h0 |->
			((zone_trip & ~$past(zone_trip)) &
			~($past(zone_pickup) | $past(zone_pickup, 2))) == 4'h0;
	endproperty
	a_trip_cause: assert property (p_trip_cause)
		else $error("zone trip rose without pick-up");
	property p_block_cause;
		(zone_blocked & ~$past(zone_blocked)) != 4'h0 |->
			$past(stage_block) || $past(stage_block, 2);
	endproperty
	a_block_cause: assert property (p_block_cause)
		else $error("blocked rose with blocking inactive");
	// ==========================================================
	// common signals, node behaviour and event stamp
	property p_extra_start;
		$rose(extra_start) |-> ##[1:LIM] (common_start || !extra_start);
	endproperty
	a_extra_start: assert property (p_extra_start)
		else $error("extra start not seen on common start");
	property p_extra_trip;
		$rose(extra_trip) |-> ##[1:LIM] (common_trip || !extra_trip);
	endproperty
	a_extra_trip: assert property (p_extra_trip)
		else $error("extra trip not seen on common trip");
	property p_cond;
		common_cond == (common_trip ? arc_trip_pkg::COND_TRIP :
			common_start ? arc_trip_pkg::COND_START :
			arc_trip_pkg::COND_NORMAL);
	endproperty
	a_cond: assert property (p_cond)
		else $error("common condition disagrees with outputs");
	property p_ln_hidden;
		!ln_visible |-> ln_behaviour == arc_trip_pkg::LN_ON;
	endproperty
	a_ln_hidden: assert property (p_ln_hidden)
		else $error("node behaviour shown while hidden");
	property p_stamp;
		event_out.valid |-> event_out.stamp <= rtc_ms;
	endproperty
	a_stamp: assert property (p_stamp)
		else $error("event stamp later than clock");
endmodule

bind arc_trip_event_logic arc_trip_event_logic_asserts #(
	.PROG_CYCLES(PROG_CYCLES)
) arc_trip_event_logic_asserts_inst (
	.aclk, .aresetn, .stage_block, .zone_pickup, .rtc_ms, .extra_start,
	.extra_trip, .zone_trip, .zone_blocked, .common_start, .common_trip,
	.common_cond, .ln_visible, .ln_behaviour, .event_out
);

// File: arc_trip_event_logic_tb_top.sv
// self-checking bench for the arc trip block over AXI4-Lite
// assumes the design, package, defines and the source model
`include "arc_trip_defines.svh"
module arc_trip_event_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// short program cycle keeps the run brief
	localparam int PC = 16;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        stage_block, extra_start, extra_trip;
	logic [3:0]  zone_pickup, zone_trip, zone_blocked;
	logic [47:0] rtc_ms;
	logic        want_block = 1'b0;
	logic [3:0]  want_pickup = 4'h0;
	logic [1:0]  want_extra = 2'h0;
	logic [7:0]  stage_start = 8'h00, stage_trip = 8'h00;
	logic [2:0]  active_group = 3'h5;
	logic        common_start, common_trip, ln_visible;
	arc_trip_pkg::sensor_type  sensors = '0;
	arc_trip_pkg::current_type currents = 64'h0123456789ABCDEF;
	arc_trip_pkg::cond_type    common_cond;
	arc_trip_pkg::ln_type      ln_behaviour;
	arc_trip_pkg::event_type   event_out;
	int          n_errors = 0, checks_done = 0;

	arc_trip_event_logic #(.PROG_CYCLES(PC)) arc_trip_event_logic_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .stage_block, .zone_pickup,
		.sensors, .currents, .active_group, .rtc_ms, .stage_start,
		.stage_trip, .extra_start, .extra_trip, .zone_trip,
		.zone_blocked, .common_start, .common_trip, .common_cond,
		.ln_visible, .ln_behaviour, .event_out);
	arc_trip_sources #(.PROG_CYCLES(PC)) arc_trip_sources_inst (
		.aclk, .want_block, .want_pickup, .want_extra, .stage_block,
		.zone_pickup, .extra_start, .extra_trip, .rtc_ms);

	initial forever #20 aclk = ~aclk;
	// ==========================================================
	// bus and compare tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw_ok) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_ok) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk({n, "_resp"}, `RESP_OKAY, r);
		chk(n, e & m, d & m);
	endtask
	task automatic tk(input int n);
		repeat (n * PC) @(posedge aclk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// watchdog, far above the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		tally_and_finish();
	end
	// ==========================================================
	// tests
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("on_sel", `OFS_ON_SEL, 32'hFFFFFFFF, 32'h0FFFFFFF);
		rchk("off_sel", `OFS_OFF_SEL, 32'hFFFFFFFF, 32'h0FFFFFFF);
		rchk("ctrl", `OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rchk("count", `OFS_COUNT, 32'hFFFFFFFF, 32'h00000000);
		rd(8'h40, d, r);
		chk("bad_rresp", `RESP_SLVERR, r);
		wr(8'h40, 32'h00000001, r);
		chk("bad_bresp", `RESP_SLVERR, r);
		wr(`OFS_COND, 32'hFFFFFFFF, r);
		rchk("cond_ro", `OFS_COND, 32'h3FF, 32'h000);
		$display("test reset_and_bus done");
		want_pickup <= 4'h1;
		tk(3);
		chk("trip", 32'h1, zone_trip);
		chk("trip_blk", 32'h0, zone_blocked);
		rchk("cond_trip", `OFS_COND, 32'h0FF, 32'h001);
		rchk("arc_on", `OFS_COUNT, 32'hFFFF, 32'h1);
		want_pickup <= 4'h0;
		tk(3);
		chk("trip_off", 32'h0, zone_trip);
		rchk("arc_off", `OFS_COUNT, 32'hFFFF, 32'h2);
		wr(`OFS_CMD, 32'h1, r);
		rchk("arc_clr", `OFS_COUNT, 32'hFFFF, 32'h0);
		$display("test trip done");
		want_block <= 1'b1;
		tk(2);
		want_pickup <= 4'h2;
		tk(3);
		chk("blocked", 32'h2, zone_blocked);
		chk("blk_trip", 32'h0, zone_trip);
		rchk("cond_blk", `OFS_COND, 32'h0FF, 32'h020);
		want_pickup <= 4'h0;
		want_block <= 1'b0;
		tk(3);
		$display("test blocked done");
		for (int i = 0; i < 13; i++) begin
			want_pickup <= 4'h4;
			tk(3);
			want_pickup <= 4'h0;
			tk(3);
		end
		rchk("rec_head", `OFS_REC_SEL, 32'hF0, 32'h20);
		wr(`OFS_REC_SEL, 32'h00000001, r);
		rchk("rec_w1", `OFS_REC_W1, 32'h1FFF, 32'h150);
		rchk("rec_w3", `OFS_REC_W3, 32'hFFFFFFFF, 32'h89ABCDEF);
		wr(`OFS_REC_SEL, 32'h0000000C, r);
		rchk("rec_none", `OFS_REC_W0, 32'hFFFFFFFF, 32'h0);
		$display("test records done");
		sensors <= arc_trip_pkg::sensor_type'(17'h1A5C3);
		tk(2);
		rchk("sensor", `OFS_SENSOR, 32'h1FFFF, 32'h1A5C3);
		sensors <= '0;
		$display("test sensors done");
		stage_start <= 8'hFF;
		tk(3);
		chk("gated", 32'h0, common_start);
		wr(`OFS_STAGE_EN, 32'h000000FF, r);
		for (int i = 0; i < 4; i++) begin
			stage_start <= (i == 0) ? 8'h08 : 8'h00;
			stage_trip <= (i == 1) ? 8'h20 : 8'h00;
			want_extra <= {i == 2, i == 3};
			want_block <= (i == 3);
			tk(3);
			chk("c_start", i == 0 || i == 2, common_start);
			chk("c_trip", i == 1 || i == 3, common_trip);
		end
		want_extra <= 2'h0;
		want_block <= 1'b0;
		tk(3);
		rd(`OFS_COUNT, d, r);
		chk("com_cnt", 32'h12, d[31:16]);
		wr(`OFS_CMD, 32'h2, r);
		rchk("com_clr", `OFS_COUNT, 32'hFFFF0000, 32'h0);
		$display("test common done");
		for (int f = 0; f < 3; f++) begin
			wr(`OFS_CTRL, 32'h1 | (f << 2), r);
			tk(3);
			chk("f_start", f != 0, common_start);
			chk("f_trip", f == 2, common_trip);
			chk("f_cond", f, common_cond);
		end
		wr(`OFS_CTRL, 32'h00000008, r);
		tk(3);
		chk("f_off", 32'h0, common_trip);
		$display("test force done");
		for (int m = 0; m < 5; m++) begin
			wr(`OFS_CTRL, 32'h2 | (m << 4), r);
			repeat (2) @(posedge aclk);
			chk("ln_vis", 32'h1, ln_visible);
			chk("ln_mode", m, ln_behaviour);
		end
		wr(`OFS_CTRL, 32'h00000020, r);
		repeat (2) @(posedge aclk);
		chk("ln_hide", 32'h0, ln_visible);
		chk("ln_on", arc_trip_pkg::LN_ON, ln_behaviour);
		$display("test node done");
		tally_and_finish();
	end
endmodule

// File: arc_trip_pkg.sv
// types shared by the arc trip block
// assumes nothing of its surroundings
package arc_trip_pkg;
	typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP} force_type;
	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP} cond_type;
	typedef enum logic [2:0] {LN_ON, LN_BLOCKED, LN_TEST, LN_TEST_BLOCKED,
		LN_OFF} ln_type;
	typedef struct packed {
		logic       ph_blocked;
		logic       ph_start;
		logic       res_blocked;
		logic       res_start;
		logic [3:0] light;
		logic [3:0] pressure;
		logic       di;
		logic [3:0] sensor_fault;
		logic       io_fault;
	} sensor_type;
	typedef struct packed {
		logic [15:0] ia;
		logic [15:0] ib;
		logic [15:0] ic;
		logic [15:0] i0;
	} current_type;
	typedef struct packed {
		logic [47:0] stamp;
		logic [5:0]  code;
		logic [2:0]  group;
		logic [3:0]  sensors;
		current_type cur;
	} record_type;
	typedef struct packed {
		logic        valid;
		logic [5:0]  code;
		logic [47:0] stamp;
	} event_type;
endpackage

// File: arc_trip_sources.sv
// blocking matrix, pick-up sources, user logic and a millisecond clock
// assumes bench requests change just after a rising edge
module arc_trip_sources #(
	parameter int PROG_CYCLES = 25000
) (
	// clock
	input wire logic         aclk,
	// requests from the bench
	input wire logic         want_block,
	input wire logic [3:0]   want_pickup,
	input wire logic [1:0]   want_extra,
	// lines into the block
	output logic             stage_block = 1'b0,
	output logic [3:0]       zone_pickup = 4'h0,
	output logic             extra_start = 1'b0,
	output logic             extra_trip = 1'b0,
	output logic [47:0]      rtc_ms = 48'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pick_dly = 4'h0;
	int         sub = 0;
	// ==========================================================
	// pick-up lags blocking by a stage, so a block leads its pick-up
	always @(posedge aclk) begin
		stage_block <= want_block;
		pick_dly <= want_pickup;
		zone_pickup <= pick_dly;
		extra_start <= want_extra[1];
		extra_trip <= want_extra[0];
		sub <= (sub == PROG_CYCLES - 1) ? 0 : sub + 1;
		if (sub == PROG_CYCLES - 1)
			rtc_ms <= rtc_ms + 48'h1;
	end
endmodule
